// >>> fsc_dsm.sv
/*
  fsc_dsm: third-order cascaded delta-sigma modulator with modulo
  64000 accumulators, stepped once per reference tick.
  Assumes frac is always below the modulus and held steady between ticks.
*/
`timescale 1ns/1ps
module fsc_dsm (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control side
  fsc_dsm_if.mdl dsm
);

  logic [fsc_pkg::ACC_W-1:0] acc1_reg, acc2_reg, acc3_reg;  // accumulators
  logic [fsc_pkg::ACC_W-1:0] s1, s2, s3;                     // raw sums
  logic c1, c2, c3;                                          // stage carries
  logic [fsc_pkg::ACC_W-1:0] a1_next, a2_next, a3_next;
  logic c2_d_reg, c3_d_reg, c3_dd_reg;                       // carry history
  logic signed [3:0] y;                                      // noise-shaped step

  // each stage wraps at the modulus; the carry is the stage output
  always_comb begin
    s1 = acc1_reg + {1'b0, dsm.frac};
    c1 = (s1 >= fsc_pkg::FRAC_MOD);
    a1_next = c1 ? s1 - fsc_pkg::FRAC_MOD : s1;
    s2 = acc2_reg + a1_next;
    c2 = (s2 >= fsc_pkg::FRAC_MOD);
    a2_next = c2 ? s2 - fsc_pkg::FRAC_MOD : s2;
    s3 = acc3_reg + a2_next;
    c3 = (s3 >= fsc_pkg::FRAC_MOD);
    a3_next = c3 ? s3 - fsc_pkg::FRAC_MOD : s3;
    // mash combination: c1 + (1-z^-1)c2 + (1-z^-1)^2 c3
    y = 4'(c1) + 4'(c2) - 4'(c2_d_reg) + 4'(c3) - 4'({c3_d_reg, 1'b0}) + 4'(c3_dd_reg);
  end

  // accumulators step only on a reference tick and clear in any cycle the modulator is not running
  always_ff @(posedge clk) begin
    if (sys_rst || !dsm.run) begin
      acc1_reg <= '0;
      acc2_reg <= '0;
      acc3_reg <= '0;
      c2_d_reg <= 1'b0;
      c3_d_reg <= 1'b0;
      c3_dd_reg <= 1'b0;
    end else if (dsm.ref_tick) begin
      acc1_reg <= a1_next;
      acc2_reg <= a2_next;
      acc3_reg <= a3_next;
      c2_d_reg <= c2;
      c3_d_reg <= c3;
      c3_dd_reg <= c3_d_reg;
    end
  end

  // divide value seen by the loop divider, registered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dsm.div_n <= '0;
    end else if (!dsm.run) begin
      dsm.div_n <= {1'b0, dsm.int_n};
    end else if (dsm.ref_tick) begin
      dsm.div_n <= fsc_pkg::DIV_W'($signed({1'b0, dsm.int_n}) + y);
    end
  end

endmodule

// >>> fsc_dsm_if.sv
/*
  fsc_dsm_if: carrier between the control logic and the delta-sigma
  modulator. Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface fsc_dsm_if;
  logic ref_tick;                           // one pulse per reference period
  logic run;                                // modulator enabled
  logic [fsc_pkg::N_W-1:0] int_n;           // integer divide part
  logic [fsc_pkg::FRAC_W-1:0] frac;         // fraction word, below modulus
  logic [fsc_pkg::DIV_W-1:0] div_n;         // instantaneous divide value

  modport ctrl (output ref_tick, output run, output int_n, output frac, input div_n);
  modport mdl (input ref_tick, input run, input int_n, input frac, output div_n);
endinterface

// >>> fsc_host_model.sv
/*
  fsc_host_model: host that programs the registers and states the mode.
  Assumes a byte strobe port on the rising edge.
*/
`timescale 1ns/1ps
module fsc_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [fsc_pkg::ADDR_W-1:0] reg_addr,
  output logic [fsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_rdata,
  // mode request
  output logic synth_req,
  output logic fast_turn
);
  // idle bus, mode off
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, synth_req, fast_turn} = 19'h00000;
  end
  // one byte write; released data shows the inverse, never the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // one byte read; data is registered, so taken a cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // the host only states the mode; the sequencer does every step
  task automatic mode(input logic req, input logic fast);
    @(negedge clk);
    synth_req = req;
    fast_turn = fast;
  endtask
endmodule

// >>> fsc_pkg.sv
/*
  fsc_pkg: register map, field layout, timing and states of the
  synthesizer frequency control block.
  Assumes a 200 MHz system clock and a 10 MHz loop reference.
*/
package fsc_pkg;

  // register port geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [6:0] REG_TRIM_LO = 7'h73;
  localparam logic [6:0] REG_TRIM_HI = 7'h74;
  localparam logic [6:0] REG_BAND = 7'h75;
  localparam logic [6:0] REG_FRAC_HI = 7'h76;
  localparam logic [6:0] REG_FRAC_LO = 7'h77;

  // reset values
  localparam logic [7:0] RST_TRIM_LO = 8'h00;
  localparam logic [7:0] RST_TRIM_HI = 8'h00;
  localparam logic [7:0] RST_BAND = 8'h35;
  localparam logic [7:0] RST_FRAC_HI = 8'hBB;
  localparam logic [7:0] RST_FRAC_LO = 8'h80;

  // band register layout
  localparam int BAND_HB_BIT = 5;
  localparam int BAND_SB_BIT = 6;
  localparam int FB_W = 5;
  localparam logic [4:0] FB_MAX = 5'h17;
  localparam logic [5:0] N_OFFSET = 6'h18;

  // trim and deviation words
  localparam int TRIM_W = 10;
  localparam int TRIM_HI_W = 2;
  localparam int DEV_W = 9;
  localparam int DEV_SHIFT_LB = 2;
  localparam int DEV_SHIFT_HB = 1;

  // modulator
  localparam int FRAC_W = 16;
  localparam int ACC_W = 17;
  localparam int N_W = 6;
  localparam int DIV_W = 7;
  localparam logic [16:0] FRAC_MOD = 17'h0FA00;

  // clocks
  localparam int CLK_HZ = 200_000_000;
  localparam int REF_HZ = 10_000_000;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int REF_CNT_W = 5;

  // sequencer times in ns and derived cycle counts
  localparam int BIAS_TIME_NS = 50_000;
  localparam int CAL_TIME_NS = 50_000;
  localparam int SETTLE_TIME_NS = 100_000;
  localparam int TOTAL_MAX_NS = 200_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int BIAS_CYC = BIAS_TIME_NS * CLK_PER_US / 1000;
  localparam int CAL_CYC = CAL_TIME_NS * CLK_PER_US / 1000;
  localparam int SETTLE_CYC = SETTLE_TIME_NS * CLK_PER_US / 1000;
  localparam int TOTAL_MAX_CYC = TOTAL_MAX_NS * CLK_PER_US / 1000;
  localparam int SEQ_CNT_W = 16;

  // start-up sequencer states
  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_BIAS,
    SEQ_CAL,
    SEQ_SETTLE,
    SEQ_LOCK
  } fsc_seq_type;

endpackage

// >>> fsc_synth_ctrl.sv
/*
  fsc_synth_ctrl: frequency control registers, fraction assembly and
  start-up sequencer of a fractional-N carrier synthesizer.
  Assumes the serial register port logic hands over decoded byte
  accesses on this clock, and tx_data arrives from a pin.
*/
`timescale 1ns/1ps
module fsc_synth_ctrl #(
  parameter int BIAS_CYCLES = fsc_pkg::BIAS_CYC,
  parameter int CAL_CYCLES = fsc_pkg::CAL_CYC,
  parameter int SETTLE_CYCLES = fsc_pkg::SETTLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [fsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_wdata,
  output logic [fsc_pkg::DATA_W-1:0] reg_rdata,
  // mode and modulation inputs
  input wire logic synth_req,
  input wire logic fast_turn,
  input wire logic mod_en,
  input wire logic [fsc_pkg::DEV_W-1:0] deviation_word,
  input wire logic tx_data,
  // synthesizer controls
  output logic vco_bias_en,
  output logic vco_cal_active,
  output logic synth_locked,
  output logic out_div2_en,
  output logic dsm_run,
  output logic [fsc_pkg::DIV_W-1:0] div_value
);

  // stored register contents
  logic [fsc_pkg::DATA_W-1:0] trim_lo_reg;
  logic [fsc_pkg::TRIM_HI_W-1:0] trim_hi_reg;
  logic [fsc_pkg::FB_W-1:0] fb_reg;
  logic hbsel_reg;
  logic sbsel_reg;
  logic [fsc_pkg::DATA_W-1:0] frac_hi_reg;
  logic [fsc_pkg::DATA_W-1:0] frac_lo_reg;

  // words as applied to the modulator
  logic [fsc_pkg::TRIM_W-1:0] ap_trim_reg;
  logic [fsc_pkg::FB_W-1:0] ap_fb_reg;
  logic ap_hbsel_reg;
  logic [fsc_pkg::FRAC_W-1:0] ap_fc_reg;

  // sequencer
  fsc_pkg::fsc_seq_type seq_reg, seq_next;
  logic [fsc_pkg::SEQ_CNT_W-1:0] cnt_reg, cnt_next;
  logic freq_dirty_reg;                      // frequency written, not yet applied
  logic start_seq;                           // sequence begins this edge

  // reference tick generator
  logic [fsc_pkg::REF_CNT_W-1:0] ref_cnt_reg;
  logic ref_tick;

  // transmit data synchroniser
  logic tx_meta_reg, tx_sync_reg;

  // fraction assembly
  localparam int DEV_W_EXT = fsc_pkg::DEV_W + fsc_pkg::DEV_SHIFT_LB;
  logic freq_write;
  logic [fsc_pkg::DEV_W+fsc_pkg::DEV_SHIFT_LB-1:0] dev_scaled;
  logic signed [18:0] offs;
  logic signed [18:0] frac_sum;
  logic [fsc_pkg::FRAC_W-1:0] frac_word;
  logic [fsc_pkg::N_W-1:0] int_word;
  logic [fsc_pkg::N_W-1:0] n_base;

  fsc_dsm_if dsm_bus ();

  // any frequency register write marks the frequency as changed
  assign freq_write = reg_wr && (reg_addr == fsc_pkg::REG_TRIM_LO || reg_addr == fsc_pkg::REG_TRIM_HI ||
                                 reg_addr == fsc_pkg::REG_BAND || reg_addr == fsc_pkg::REG_FRAC_HI ||
                                 reg_addr == fsc_pkg::REG_FRAC_LO);

  // trim word registers, low byte and top two bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trim_lo_reg <= fsc_pkg::RST_TRIM_LO;
      trim_hi_reg <= fsc_pkg::RST_TRIM_HI[fsc_pkg::TRIM_HI_W-1:0];
    end else if (reg_wr) begin
      if (reg_addr == fsc_pkg::REG_TRIM_LO) begin
        trim_lo_reg <= reg_wdata;
      end
      if (reg_addr == fsc_pkg::REG_TRIM_HI) begin
        trim_hi_reg <= reg_wdata[fsc_pkg::TRIM_HI_W-1:0];
      end
    end
  end

  // band register; an out-of-range band is clamped as it is written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fb_reg <= fsc_pkg::RST_BAND[fsc_pkg::FB_W-1:0];
      hbsel_reg <= fsc_pkg::RST_BAND[fsc_pkg::BAND_HB_BIT];
      sbsel_reg <= fsc_pkg::RST_BAND[fsc_pkg::BAND_SB_BIT];
    end else if (reg_wr && reg_addr == fsc_pkg::REG_BAND) begin
      // clamping here keeps read-back and the divider in agreement
      if (reg_wdata[fsc_pkg::FB_W-1:0] > fsc_pkg::FB_MAX) begin
        fb_reg <= fsc_pkg::FB_MAX;
      end else begin
        fb_reg <= reg_wdata[fsc_pkg::FB_W-1:0];
      end
      hbsel_reg <= reg_wdata[fsc_pkg::BAND_HB_BIT];
      sbsel_reg <= reg_wdata[fsc_pkg::BAND_SB_BIT];
    end
  end

  // nominal fraction word, high and low bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frac_hi_reg <= fsc_pkg::RST_FRAC_HI;
      frac_lo_reg <= fsc_pkg::RST_FRAC_LO;
    end else if (reg_wr) begin
      if (reg_addr == fsc_pkg::REG_FRAC_HI) begin
        frac_hi_reg <= reg_wdata;
      end
      if (reg_addr == fsc_pkg::REG_FRAC_LO) begin
        frac_lo_reg <= reg_wdata;
      end
    end
  end

  // read data, registered; unmapped offsets and reserved bits read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        fsc_pkg::REG_TRIM_LO: reg_rdata <= trim_lo_reg;
        fsc_pkg::REG_TRIM_HI: reg_rdata <= {6'h00, trim_hi_reg};
        fsc_pkg::REG_BAND: reg_rdata <= {1'b0, sbsel_reg, hbsel_reg, fb_reg};
        fsc_pkg::REG_FRAC_HI: reg_rdata <= frac_hi_reg;
        fsc_pkg::REG_FRAC_LO: reg_rdata <= frac_lo_reg;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // frequency change flag; a write in the start cycle still counts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      freq_dirty_reg <= 1'b0;
    end else if (freq_write) begin
      freq_dirty_reg <= 1'b1;
    end else if (start_seq) begin
      freq_dirty_reg <= 1'b0;
    end
  end

  // a fresh request or a changed frequency restarts the sequence
  assign start_seq = synth_req && (seq_reg == fsc_pkg::SEQ_OFF || freq_dirty_reg);

  // latch the programmed words only when a sequence starts; with the request high each byte write
  // starts one, so the modulator can see a half-written word until the next byte lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ap_trim_reg <= {fsc_pkg::RST_TRIM_HI[fsc_pkg::TRIM_HI_W-1:0], fsc_pkg::RST_TRIM_LO};
      ap_fb_reg <= fsc_pkg::RST_BAND[fsc_pkg::FB_W-1:0];
      ap_hbsel_reg <= fsc_pkg::RST_BAND[fsc_pkg::BAND_HB_BIT];
      ap_fc_reg <= {fsc_pkg::RST_FRAC_HI, fsc_pkg::RST_FRAC_LO};
    end else if (start_seq) begin
      ap_trim_reg <= {trim_hi_reg, trim_lo_reg};
      ap_fb_reg <= fb_reg;
      ap_hbsel_reg <= hbsel_reg;
      ap_fc_reg <= {frac_hi_reg, frac_lo_reg};
    end
  end

  // sequencer next state: bias settle, calibration, loop settle, locked
  always_comb begin
    seq_next = seq_reg;
    cnt_next = cnt_reg;
    if (!synth_req) begin
      seq_next = fsc_pkg::SEQ_OFF;
      cnt_next = '0;
    end else if (start_seq) begin
      cnt_next = '0;
      if (fast_turn) begin
        seq_next = fsc_pkg::SEQ_SETTLE;
      end else begin
        seq_next = fsc_pkg::SEQ_BIAS;
      end
    end else begin
      cnt_next = cnt_reg + 1'b1;
      unique case (seq_reg)
        fsc_pkg::SEQ_OFF: begin
          cnt_next = '0;
        end
        fsc_pkg::SEQ_BIAS: begin
          if (cnt_reg == fsc_pkg::SEQ_CNT_W'(BIAS_CYCLES - 1)) begin
            seq_next = fsc_pkg::SEQ_CAL;
            cnt_next = '0;
          end
        end
        fsc_pkg::SEQ_CAL: begin
          if (cnt_reg == fsc_pkg::SEQ_CNT_W'(CAL_CYCLES - 1)) begin
            seq_next = fsc_pkg::SEQ_SETTLE;
            cnt_next = '0;
          end
        end
        fsc_pkg::SEQ_SETTLE: begin
          // bias + cal + settle defaults sum to exactly the 200 us budget
          if (cnt_reg == fsc_pkg::SEQ_CNT_W'(SETTLE_CYCLES - 1)) begin
            seq_next = fsc_pkg::SEQ_LOCK;
            cnt_next = '0;
          end
        end
        fsc_pkg::SEQ_LOCK: begin
          cnt_next = '0;
        end
      endcase
    end
  end

  // sequencer state and interval counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_reg <= fsc_pkg::SEQ_OFF;
      cnt_reg <= '0;
    end else begin
      seq_reg <= seq_next;
      cnt_reg <= cnt_next;
    end
  end

  // sequencer-driven controls, all straight from flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vco_bias_en <= 1'b0;
      vco_cal_active <= 1'b0;
      synth_locked <= 1'b0;
      dsm_run <= 1'b0;
    end else begin
      vco_bias_en <= (seq_next != fsc_pkg::SEQ_OFF);
      vco_cal_active <= (seq_next == fsc_pkg::SEQ_CAL);
      synth_locked <= (seq_next == fsc_pkg::SEQ_LOCK);
      dsm_run <= (seq_next != fsc_pkg::SEQ_OFF);
    end
  end

  // divide-by-two after the loop is used only in the low band; the two
  // halves together cover the whole tuning range
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_div2_en <= ~fsc_pkg::RST_BAND[fsc_pkg::BAND_HB_BIT];
    end else begin
      out_div2_en <= ~ap_hbsel_reg;
    end
  end

  // 10 MHz reference tick derived from the system clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_cnt_reg <= '0;
    end else if (ref_cnt_reg == fsc_pkg::REF_CNT_W'(fsc_pkg::REF_DIV - 1)) begin
      ref_cnt_reg <= '0;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 1'b1;
    end
  end
  assign ref_tick = (ref_cnt_reg == fsc_pkg::REF_CNT_W'(fsc_pkg::REF_DIV - 1));

  // transmit bit from a pin: two flops before any use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_meta_reg <= 1'b0;
      tx_sync_reg <= 1'b0;
    end else begin
      tx_meta_reg <= tx_data;
      tx_sync_reg <= tx_meta_reg;
    end
  end

  // fraction assembly: nominal + signed trim +/- scaled deviation, then
  // carry into the integer part so the fraction stays below the modulus
  always_comb begin
    // deviation is 625 Hz per step: 4 lsb in low band, 2 in high band
    if (ap_hbsel_reg) begin
      dev_scaled = DEV_W_EXT'({deviation_word, 1'b0});
    end else begin
      dev_scaled = {deviation_word, 2'b00};
    end
    // trim lsb is 156.25 Hz x (hbsel+1), same as one fraction lsb
    offs = 19'(signed'(ap_trim_reg));
    if (mod_en) begin
      if (tx_sync_reg) begin
        offs = offs + 19'(signed'({1'b0, dev_scaled}));
      end else begin
        offs = offs - 19'(signed'({1'b0, dev_scaled}));
      end
    end
    frac_sum = 19'(signed'({1'b0, ap_fc_reg})) + offs;
    n_base = {1'b0, ap_fb_reg} + fsc_pkg::N_OFFSET;
    if (frac_sum < 0) begin
      frac_word = fsc_pkg::FRAC_W'(frac_sum + 19'(signed'({2'b00, fsc_pkg::FRAC_MOD})));
      int_word = n_base - 1'b1;
    end else if (frac_sum >= 19'(signed'({2'b00, fsc_pkg::FRAC_MOD}))) begin
      frac_word = fsc_pkg::FRAC_W'(frac_sum - 19'(signed'({2'b00, fsc_pkg::FRAC_MOD})));
      int_word = n_base + 1'b1;
    end else begin
      frac_word = fsc_pkg::FRAC_W'(frac_sum);
      int_word = n_base;
    end
  end


  // modulator feed; a start clears the accumulators so old words leave no trace
  assign dsm_bus.ref_tick = ref_tick;
  assign dsm_bus.run = dsm_run && !start_seq;
  assign dsm_bus.int_n = int_word;
  assign dsm_bus.frac = frac_word;
  assign div_value = dsm_bus.div_n;

  // third-order modulator stepped at the reference rate
  fsc_dsm u_dsm (
    .clk(clk),
    .sys_rst(sys_rst),
    .dsm(dsm_bus.mdl)
  );

endmodule

// >>> fsc_synth_ctrl_sva.sv
/*
  fsc_synth_ctrl_sva: port-level checks of register readback and of the
  start-up sequencer timing of fsc_synth_ctrl.
  Assumes no request drop or write during calibration.
*/
`timescale 1ns/1ps
module fsc_synth_ctrl_sva #(
  parameter int BIAS_CYCLES = 8,
  parameter int CAL_CYCLES = 8,
  parameter int SETTLE_CYCLES = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [fsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_rdata,
  // mode
  input wire logic synth_req,
  input wire logic fast_turn,
  // synthesizer controls
  input wire logic vco_bias_en,
  input wire logic vco_cal_active,
  input wire logic synth_locked,
  input wire logic dsm_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr_freq; // write that lands on a frequency register
  logic [15:0] seq_cnt; // cycles since the sequence last (re)started
  logic [15:0] cal_cnt; // cycles spent calibrating
  int lock_lo; // earliest lock count for the chosen path
  assign wr_freq = reg_wr && reg_addr >= fsc_pkg::REG_TRIM_LO && reg_addr <= fsc_pkg::REG_FRAC_LO;
  assign lock_lo = fast_turn ? SETTLE_CYCLES : BIAS_CYCLES + CAL_CYCLES + SETTLE_CYCLES;
  // a write restarts the count; the dirty flag adds one cycle
  always_ff @(posedge clk) begin
    if (sys_rst || !vco_bias_en || wr_freq) begin
      seq_cnt <= 16'h0000;
    end else begin
      seq_cnt <= seq_cnt + 16'h0001;
    end
  end
  // length of the calibration pulse
  always_ff @(posedge clk) begin
    if (sys_rst || !vco_cal_active) begin
      cal_cnt <= 16'h0000;
    end else begin
      cal_cnt <= cal_cnt + 16'h0001;
    end
  end
  sequence no_cal_run;
    !vco_cal_active [*8];
  endsequence
  sequence cal_phase;
    vco_cal_active && vco_bias_en && !synth_locked;
  endsequence
  start_bias_a: assert property (synth_req && !vco_bias_en |=> vco_bias_en && dsm_run)
    else $error("bias late");
  req_off_a: assert property (!synth_req |=> !vco_bias_en && !vco_cal_active && !synth_locked)
    else $error("still on after drop");
  cal_inside_a: assert property (vco_cal_active |-> cal_phase)
    else $error("cal outside bias");
  bias_len_a: assert property ($rose(vco_cal_active) |-> seq_cnt >= BIAS_CYCLES && seq_cnt <= BIAS_CYCLES + 1)
    else $error("bias length");
  cal_len_a: assert property ($fell(vco_cal_active) && $past(synth_req) |-> cal_cnt == CAL_CYCLES)
    else $error("cal length");
  lock_time_a: assert property ($rose(synth_locked) |-> seq_cnt >= lock_lo && seq_cnt <= lock_lo + 1)
    else $error("lock time");
  total_max_a: assert property (vco_bias_en && !synth_locked |-> seq_cnt <= BIAS_CYCLES + CAL_CYCLES + SETTLE_CYCLES + 1)
    else $error("sequence overran");
  fast_skip_a: assert property ($rose(vco_bias_en) && fast_turn |-> no_cal_run)
    else $error("cal on fast start");
  lock_hold_a: assert property (synth_locked && synth_req && !wr_freq && !$past(wr_freq) |=> synth_locked)
    else $error("lock lost");
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (reg_rd && (reg_addr < fsc_pkg::REG_TRIM_LO || reg_addr > fsc_pkg::REG_FRAC_LO)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  band_sat_a: assert property (reg_rd && reg_addr == fsc_pkg::REG_BAND |=> !reg_rdata[7] && reg_rdata[4:0] <= 5'h17)
    else $error("band above limit");
endmodule
bind fsc_synth_ctrl fsc_synth_ctrl_sva #(
  .BIAS_CYCLES(BIAS_CYCLES), .CAL_CYCLES(CAL_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)
) u_fsc_synth_ctrl_sva (
  .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .synth_req(synth_req), .fast_turn(fast_turn), .vco_bias_en(vco_bias_en),
  .vco_cal_active(vco_cal_active), .synth_locked(synth_locked), .dsm_run(dsm_run)
);

// >>> testbench.sv
/*
  testbench: self-checking bench for fsc_synth_ctrl driven by a host model.
  Assumes shortened sequencer counts of 8, 8 and 16 cycles.
*/
`timescale 1ns/1ps
module testbench;
  localparam int BIAS = 8; // shortened bias settle
  localparam int CAL = 8; // shortened calibration
  localparam int SETTLE = 16; // shortened loop settle
  logic clk, sys_rst, reg_wr, reg_rd, synth_req, fast_turn, mod_en, tx_data;
  logic [6:0] reg_addr, div_value;
  logic [7:0] reg_wdata, reg_rdata;
  logic [8:0] deviation_word;
  logic vco_bias_en, vco_cal_active, synth_locked, out_div2_en, dsm_run;
  int miscompares = 0;
  int checked = 0;
  fsc_synth_ctrl #(.BIAS_CYCLES(BIAS), .CAL_CYCLES(CAL), .SETTLE_CYCLES(SETTLE)) u_fsc_synth_ctrl (
    .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .synth_req(synth_req), .fast_turn(fast_turn),
    .mod_en(mod_en), .deviation_word(deviation_word), .tx_data(tx_data), .vco_bias_en(vco_bias_en),
    .vco_cal_active(vco_cal_active), .synth_locked(synth_locked), .out_div2_en(out_div2_en),
    .dsm_run(dsm_run), .div_value(div_value));
  fsc_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .synth_req(synth_req), .fast_turn(fast_turn));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  // sequencer output by index
  function automatic logic pick(input int which);
    case (which)
      0: pick = vco_bias_en;
      1: pick = vco_cal_active;
      default: pick = synth_locked;
    endcase
  endfunction
  // bounded wait for a level
  task automatic wait_hi(input int which, input logic lvl, output int n);
    n = 0;
    while (pick(which) !== lvl && n < 500) begin
      @(negedge clk);
      n++;
    end
  endtask
  // divide value at eight reference ticks
  task automatic chk_div(input logic [6:0] exp);
    repeat (8) begin
      repeat (20) @(negedge clk);
      chk8({1'b0, div_value}, {1'b0, exp});
    end
  endtask
  // reset values, band saturation, trim masking, unmapped offsets
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] rst_v [5] = '{fsc_pkg::RST_TRIM_LO, fsc_pkg::RST_TRIM_HI, fsc_pkg::RST_BAND,
      fsc_pkg::RST_FRAC_HI, fsc_pkg::RST_FRAC_LO};
    logic [7:0] b_in [4] = '{8'hFF, 8'h17, 8'h18, 8'h20};
    logic [7:0] b_out [4] = '{8'h77, 8'h17, 8'h17, 8'h20};
    for (int i = 0; i < 5; i++) begin
      u_host.rd(fsc_pkg::REG_TRIM_LO + 7'(i), d);
      chk8(d, rst_v[i]);
    end
    chk8({1'b0, div_value}, 8'h2D);
    chk8({7'h00, out_div2_en}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      u_host.wr(fsc_pkg::REG_BAND, b_in[i]);
      u_host.rd(fsc_pkg::REG_BAND, d);
      chk8(d, b_out[i]);
    end
    u_host.wr(fsc_pkg::REG_TRIM_HI, 8'hFF);
    u_host.rd(fsc_pkg::REG_TRIM_HI, d);
    chk8(d, 8'h03);
    u_host.wr(7'h72, 8'h55);
    u_host.rd(7'h72, d);
    chk8(d, 8'h00);
  endtask
  // cold start in low band; fraction plus trim wraps at the modulus
  task automatic t_start();
    int n;
    u_host.wr(fsc_pkg::REG_BAND, 8'h02);
    u_host.wr(fsc_pkg::REG_FRAC_HI, 8'hF9);
    u_host.wr(fsc_pkg::REG_FRAC_LO, 8'h38);
    u_host.wr(fsc_pkg::REG_TRIM_LO, 8'hC8);
    u_host.wr(fsc_pkg::REG_TRIM_HI, 8'h00);
    u_host.mode(1'b1, 1'b0);
    wait_hi(0, 1'b1, n);
    chk_rng(n, 1, 1);
    wait_hi(1, 1'b1, n);
    chk_rng(n, BIAS, BIAS + 1);
    wait_hi(2, 1'b1, n);
    chk_rng(n, CAL + SETTLE, CAL + SETTLE + 1);
    chk8({7'h00, out_div2_en}, 8'h01);
    chk_div(7'h1B);
  endtask
  // writes while locked restart the short sequence; negative trim
  task automatic t_restart();
    int n;
    u_host.mode(1'b1, 1'b1);
    u_host.wr(fsc_pkg::REG_FRAC_HI, 8'h00);
    wait_hi(2, 1'b0, n);
    chk_rng(n, 0, 2);
    u_host.wr(fsc_pkg::REG_FRAC_LO, 8'h64);
    u_host.wr(fsc_pkg::REG_TRIM_LO, 8'h9C);
    u_host.wr(fsc_pkg::REG_TRIM_HI, 8'h03);
    u_host.wr(fsc_pkg::REG_BAND, 8'h1F);
    wait_hi(2, 1'b1, n);
    chk_rng(n, SETTLE, SETTLE + 1);
    chk_div(7'h2F);
    u_host.wr(fsc_pkg::REG_BAND, 8'h37);
    wait_hi(2, 1'b0, n);
    wait_hi(2, 1'b1, n);
    chk8({7'h00, out_div2_en}, 8'h00);
    chk_div(7'h2F);
  endtask
  // dropping the request turns bias, calibration, lock and modulator run off; the divide value holds the integer part
  task automatic t_off();
    u_host.mode(1'b0, 1'b0);
    repeat (2) @(negedge clk);
    chk8({4'h0, vco_bias_en, vco_cal_active, synth_locked, dsm_run}, 8'h00);
    chk8({1'b0, div_value}, 8'h2F);
  endtask
  // deviation in both bands, then live bit changes
  task automatic t_fsk();
    int n;
    int hits;
    logic [6:0] prev;
    logic [7:0] cfg [2][3] = '{'{8'h02, 8'hF6, 8'h18}, '{8'h22, 8'hF8, 8'h0C}};
    mod_en = 1'b1;
    deviation_word = 9'h0FA;
    tx_data = 1'b1;
    u_host.wr(fsc_pkg::REG_TRIM_LO, 8'h00);
    u_host.wr(fsc_pkg::REG_TRIM_HI, 8'h00);
    for (int i = 0; i < 2; i++) begin
      u_host.mode(1'b0, 1'b1);
      u_host.wr(fsc_pkg::REG_BAND, cfg[i][0]);
      u_host.wr(fsc_pkg::REG_FRAC_HI, cfg[i][1]);
      u_host.wr(fsc_pkg::REG_FRAC_LO, cfg[i][2]);
      u_host.mode(1'b1, 1'b1);
      wait_hi(2, 1'b1, n);
      chk_div(7'h1B);
    end
    tx_data = 1'b0;
    prev = div_value;
    hits = 0;
    repeat (160) begin
      @(negedge clk);
      if (div_value !== prev) hits++;
      prev = div_value;
    end
    chk_rng(hits, 1, 8);
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    sys_rst = 1'b1;
    mod_en = 1'b0;
    deviation_word = 9'h000;
    tx_data = 1'b0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    t_regs();
    t_start();
    t_restart();
    t_off();
    t_fsk();
    close_out();
  end
  // watchdog, far past the run's length
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
